/* ddi_device.sv */
// Device side command decode, mode register zero and initialization state.
`timescale 1ns/10ps
`default_nettype none

module ddi_device #(
  parameter int INIT_CYCLES = ddi_pkg::INIT_WAIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_ck,
  input wire logic reset_pin_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic termination_ctrl_in,
  input wire logic [15:0] rd_word,
  output logic [15:0] dq_out,
  output logic dq_oe_b,
  output logic dqs_out,
  output logic dqs_oe_b,
  output logic term_enable,
  output logic act_strobe,
  output logic [2:0] act_bank,
  output logic [15:0] act_row,
  output logic acc_strobe,
  output logic acc_write,
  output logic [2:0] acc_bank,
  output logic [9:0] acc_col,
  output logic acc_autopre,
  output logic acc_chop,
  output logic mr_strobe,
  output logic [1:0] mr_sel,
  output logic [15:0] mr_data,
  output logic dll_reset,
  output logic zq_long,
  output logic [15:0] mode_register_zero,
  output logic [2:0] rd_col,
  output logic rd_beat_valid,
  output logic init_ready,
  output logic cke_seen_sys,
  output logic [1:0] cfg_burst_mode,
  output logic cfg_interleave
);

  if (INIT_CYCLES < 1)
  begin : g_bad_init_cycles
    $error("INIT_CYCLES must be at least one");
  end

  // Link domain reset: asserted at once by either reset, released on link_ck.
  wire logic link_arst_b = rst_b & reset_pin_b;
  logic lrst_meta;
  logic link_rst_b;

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      lrst_meta <= 1'b0;
      link_rst_b <= 1'b0;
    end
    else
    begin
      lrst_meta <= 1'b1;
      link_rst_b <= lrst_meta;
    end
  end

  // Command decode; a high chip select is a deselect.
  wire logic [3:0] cmd = {cs_b, ras_b, cas_b, we_b};
  wire logic sel = !cs_b;
  wire logic is_act = sel && (cmd == ddi_pkg::CMD_ACTIVE);
  wire logic is_rd = sel && (cmd == ddi_pkg::CMD_READ);
  wire logic is_wr = sel && (cmd == ddi_pkg::CMD_WRITE);
  wire logic is_mrs = sel && (cmd == ddi_pkg::CMD_MODE_WRITE);
  wire logic is_zq = sel && (cmd == ddi_pkg::CMD_IMPEDANCE_CAL);
  // Bank bit two must be low for any mode write to take effect.
  wire logic mrs_ok = is_mrs && !ba[2];
  wire logic mr0_hit = is_mrs && (ba == ddi_pkg::SEL_MODE_ZERO);

  wire logic [1:0] bl_mode =
    mode_register_zero[ddi_pkg::BURST_MODE_LSB +: 2];
  wire logic chop_otf = (bl_mode == ddi_pkg::BURST_ON_THE_FLY) &&
                        !addr[ddi_pkg::BURST_CHOP_SELECT_BIT];
  wire logic chop_now = (bl_mode == ddi_pkg::BURST_CHOP_FOUR) ||
                        chop_otf;

  logic cke_seen;
  logic mr0_tgl;

  // Termination stays off until clock enable is first registered high.
  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      cke_seen <= 1'b0;
      term_enable <= 1'b0;
    end
    else if (!link_rst_b)
    begin
      cke_seen <= 1'b0;
      term_enable <= 1'b0;
    end
    else
    begin
      cke_seen <= cke_seen | cke;
      term_enable <= cke_seen & termination_ctrl_in;
    end
  end

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      act_strobe <= 1'b0;
      act_bank <= 3'h0;
      act_row <= 16'h0000;
    end
    else
    begin
      act_strobe <= is_act && cke_seen;
      if (is_act)
      begin
        act_bank <= ba;
        act_row <= addr;
      end
    end
  end

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      acc_strobe <= 1'b0;
      acc_write <= 1'b0;
      acc_bank <= 3'h0;
      acc_col <= 10'h000;
      acc_autopre <= 1'b0;
      acc_chop <= 1'b0;
    end
    else
    begin
      acc_strobe <= (is_rd || is_wr) && cke_seen;
      if (is_rd || is_wr)
      begin
        acc_write <= is_wr;
        acc_bank <= ba;
        acc_col <= addr[9:0];
        acc_autopre <= addr[ddi_pkg::AUTO_PRECHARGE_BIT];
        acc_chop <= chop_now;
      end
    end
  end

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      mode_register_zero <= ddi_pkg::MODE_ZERO_RESET;
      mr0_tgl <= 1'b0;
      mr_strobe <= 1'b0;
      mr_sel <= 2'h0;
      mr_data <= 16'h0000;
      dll_reset <= 1'b0;
      zq_long <= 1'b0;
    end
    else
    begin
      mr_strobe <= mrs_ok && cke_seen;
      dll_reset <= mr0_hit && cke_seen &&
                   addr[ddi_pkg::DLL_RESET_BIT];
      zq_long <= is_zq && cke_seen && addr[ddi_pkg::LONG_CAL_BIT];
      if (mrs_ok)
      begin
        mr_sel <= ba[1:0];
        mr_data <= addr;
      end
      if (mr0_hit && cke_seen)
      begin
        // The reset bit clears itself; only the reset pulse is raised.
        mode_register_zero <= addr & ~(16'h0001 << ddi_pkg::DLL_RESET_BIT);
        mr0_tgl <= ~mr0_tgl;
      end
    end
  end

  // Read burst sequencer, one beat slot per link clock.
  ddi_pkg::ddi_rd_state_t rd_state;
  ddi_pkg::ddi_rd_state_t next_rd_state;
  logic [2:0] beat;
  logic [2:0] start_col;
  logic chop;
  logic interleave;
  logic [2:0] beat_col;

  ddi_beat_order u_order (
    .start_col(start_col),
    .beat(beat),
    .interleave(interleave),
    .col(beat_col)
  );

  wire logic rd_go = is_rd && cke_seen;
  wire logic beat_dead = chop && beat[ddi_pkg::CHOP_BEAT_BIT];
  wire logic beat_last = (beat == ddi_pkg::LAST_BEAT);

  always_comb
  begin
    next_rd_state = rd_state;
    case (rd_state)
      ddi_pkg::RD_IDLE:
        if (rd_go)
          next_rd_state = ddi_pkg::RD_BURST;
      ddi_pkg::RD_BURST:
        if (beat_last && !rd_go)
          next_rd_state = ddi_pkg::RD_IDLE;
      default:
        next_rd_state = ddi_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      rd_state <= ddi_pkg::RD_IDLE;
      beat <= 3'h0;
      start_col <= 3'h0;
      chop <= 1'b0;
      interleave <= 1'b0;
    end
    else
    begin
      rd_state <= next_rd_state;
      beat <= rd_go ? 3'h0 : 3'(beat + 3'h1);
      if (rd_go)
      begin
        start_col <= addr[2:0];
        chop <= chop_now;
        interleave <= mode_register_zero[ddi_pkg::BURST_TYPE_BIT];
      end
    end
  end

  wire logic beat_live = (rd_state == ddi_pkg::RD_BURST) && !beat_dead;

  always_ff @(posedge link_ck or negedge link_arst_b)
  begin
    if (!link_arst_b)
    begin
      rd_col <= 3'h0;
      rd_beat_valid <= 1'b0;
      dq_out <= 16'h0000;
      dq_oe_b <= 1'b1;
      dqs_out <= 1'b0;
      dqs_oe_b <= 1'b1;
    end
    else
    begin
      rd_col <= beat_col;
      rd_beat_valid <= beat_live;
      dq_out <= rd_word;
      dq_oe_b <= !beat_live;
      dqs_out <= beat_live & !beat[0];
      dqs_oe_b <= !beat_live;
    end
  end

  // System domain: synchronisers, internal init timer, mode status.
  logic rpin_meta;
  logic rpin_sync;
  logic cke_meta;
  logic tgl_meta;
  logic tgl_sync;
  logic tgl_prev;
  logic [31:0] init_count;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rpin_meta <= 1'b0;
      rpin_sync <= 1'b0;
      cke_meta <= 1'b0;
      cke_seen_sys <= 1'b0;
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_prev <= 1'b0;
    end
    else
    begin
      rpin_meta <= reset_pin_b;
      rpin_sync <= rpin_meta;
      cke_meta <= cke_seen;
      cke_seen_sys <= cke_meta;
      tgl_meta <= mr0_tgl;
      tgl_sync <= tgl_meta;
      tgl_prev <= tgl_sync;
    end
  end

  wire logic count_done = (init_count >= 32'(INIT_CYCLES));

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_count <= 32'h0;
      init_ready <= 1'b0;
    end
    else if (!rpin_sync)
    begin
      init_count <= 32'h0;
      init_ready <= 1'b0;
    end
    else
    begin
      init_count <= count_done ? init_count : init_count + 32'h1;
      init_ready <= count_done;
    end
  end

  // Mode word is stable long before the toggle lands here.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_burst_mode <= ddi_pkg::BURST_FULL_EIGHT;
      cfg_interleave <= 1'b0;
    end
    else if (tgl_sync != tgl_prev)
    begin
      cfg_burst_mode <= bl_mode;
      cfg_interleave <= mode_register_zero[ddi_pkg::BURST_TYPE_BIT];
    end
  end

endmodule : ddi_device

`default_nettype wire

/* ddi_beat_order.sv */
// Package of shared constants and the burst beat ordering module.
`timescale 1ns/10ps
`default_nettype none

package ddi_pkg;
  // Command codes as {chip select, row strobe, column strobe, write enable}.
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_MODE_WRITE = 4'h0;
  localparam logic [3:0] CMD_IMPEDANCE_CAL = 4'h6;
  // Address bit positions used with commands.
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int BURST_CHOP_SELECT_BIT = 12;
  localparam int LONG_CAL_BIT = 10;
  // Field layout of mode_register_zero.
  localparam int BURST_MODE_LSB = 0;
  localparam int BURST_TYPE_BIT = 3;
  localparam int DLL_RESET_BIT = 8;
  localparam logic [15:0] MODE_ZERO_RESET = 16'h0000;
  // Burst length field codes.
  localparam logic [1:0] BURST_FULL_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_CHOP_FOUR = 2'h2;
  // Bank address codes selecting the mode register.
  localparam logic [2:0] SEL_MODE_ZERO = 3'h0;
  localparam logic [2:0] SEL_MODE_ONE = 3'h1;
  localparam logic [2:0] SEL_MODE_TWO = 3'h2;
  localparam logic [2:0] SEL_MODE_THREE = 3'h3;
  // Burst geometry.
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam int CHOP_BEAT_BIT = 2;
  // Internal initialization wait after reset release.
  localparam int INIT_WAIT_US = 500;
  localparam int CLOCK_MHZ = 100;
  localparam int INIT_WAIT_CYCLES = INIT_WAIT_US * CLOCK_MHZ;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_BURST = 1'b1
  } ddi_rd_state_t;
endpackage : ddi_pkg

module ddi_beat_order (
  input wire logic [2:0] start_col,
  input wire logic [2:0] beat,
  input wire logic interleave,
  output logic [2:0] col
);

  // Nibble half flips past beat three; low bits wrap or exclusive-or.
  function automatic logic [2:0] beat_col(input logic [2:0] s,
                                          input logic [2:0] b,
                                          input logic il);
    logic [1:0] low;
    low = il ? (s[1:0] ^ b[1:0]) : 2'(s[1:0] + b[1:0]);
    beat_col = {s[2] ^ b[2], low};
  endfunction : beat_col

  assign col = beat_col(start_col, beat, interleave);

endmodule : ddi_beat_order

`default_nettype wire

/* ddi_device_checker.sv */
// Checker of command capture and read beat behaviour at the device ports.
`timescale 1ns/10ps
`default_nettype none

module ddi_device_checker (
  input wire logic link_ck,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic act_strobe,
  input wire logic [2:0] act_bank,
  input wire logic [15:0] act_row,
  input wire logic acc_strobe,
  input wire logic acc_write,
  input wire logic [9:0] acc_col,
  input wire logic acc_autopre,
  input wire logic mr_strobe,
  input wire logic [1:0] mr_sel,
  input wire logic [15:0] mr_data,
  input wire logic dll_reset,
  input wire logic zq_long,
  input wire logic term_enable,
  input wire logic [2:0] rd_col,
  input wire logic rd_beat_valid,
  input wire logic dq_oe_b,
  input wire logic dqs_oe_b
);
  logic seen;
  logic [1:0] rc;
  wire arst_b = rst_b & reset_pin_b;
  wire [3:0] code = {cs_b, ras_b, cas_b, we_b};
  // Commands count only once clock enable was seen and the reset sync ran.
  wire ok = seen && rc == 2'h3;
  wire rd = ok && code == ddi_pkg::CMD_READ;
  wire acc = rd || (ok && code == ddi_pkg::CMD_WRITE);
  wire mw = ok && code == ddi_pkg::CMD_MODE_WRITE;
  wire a8 = addr[8];
  wire a10 = addr[10];
  wire [2:0] scol = addr[2:0];
  wire [9:0] ccol = addr[9:0];
  always_ff @(posedge link_ck or negedge arst_b)
    if (!arst_b)
    begin
      seen <= 1'b0;
      rc <= 2'h0;
    end
    else
    begin
      seen <= seen | cke;
      rc <= rc + {1'b0, rc != 2'h3};
    end
  default clocking cb @(posedge link_ck); endclocking
  default disable iff (!arst_b);
  property p_act;
    ok && code == ddi_pkg::CMD_ACTIVE |=> act_strobe &&
      act_bank == $past(ba) && act_row == $past(addr);
  endproperty
  a_act: assert property (p_act) else $error("active not captured");
  property p_acc;
    acc |=> acc_strobe && acc_write == !$past(we_b) &&
      acc_col == $past(ccol) && acc_autopre == $past(a10);
  endproperty
  a_acc: assert property (p_acc) else $error("access not captured");
  property p_mr;
    mw && !ba[2] |=> mr_strobe && {1'b0, mr_sel} == $past(ba) &&
      mr_data == $past(addr);
  endproperty
  a_mr: assert property (p_mr) else $error("mode write not captured");
  property p_rsv;
    mw && ba[2] |=> !mr_strobe;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bank accepted");
  property p_dll;
    mw && ba == 3'h0 |=> dll_reset == $past(a8);
  endproperty
  a_dll: assert property (p_dll) else $error("dll reset pulse wrong");
  property p_zq;
    ok && code == ddi_pkg::CMD_IMPEDANCE_CAL |=> zq_long == $past(a10);
  endproperty
  a_zq: assert property (p_zq) else $error("long cal pulse wrong");
  property p_des;
    cs_b |=> !(act_strobe || acc_strobe || mr_strobe);
  endproperty
  a_des: assert property (p_des) else $error("deselect not ignored");
  property p_off;
    !seen |-> !term_enable;
  endproperty
  a_off: assert property (p_off) else $error("termination on early");
  property p_beat;
    rd |-> ##2 rd_beat_valid && rd_col == $past(scol, 2);
  endproperty
  a_beat: assert property (p_beat) else $error("first beat wrong");
  property p_hiz;
    !rd_beat_valid |-> dq_oe_b && dqs_oe_b;
  endproperty
  a_hiz: assert property (p_hiz) else $error("idle beat driven");
endmodule : ddi_device_checker

`default_nettype wire

/* ddi_ctrl_model.sv */
// Controller model that drives the device reset, enable and command pins.
`timescale 1ns/10ps
`default_nettype none

module ddi_ctrl_model #(
  parameter int WAIT_CYC = 40,
  parameter int GAP = 12
) (
  input wire logic link_ck,
  output logic reset_pin_b,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [2:0] ba,
  output logic [15:0] addr,
  output logic termination_ctrl_in
);
  // Waits are shortened stand-ins for the real timings.
  initial
  begin
    reset_pin_b = 1'b0;
    cke = 1'b0;
    {cs_b, ras_b, cas_b, we_b} = 4'hf;
    ba = 3'h0;
    addr = 16'h0;
    termination_ctrl_in = 1'b1;
  end
  // Write recovery count in link clocks, rounded up from the recovery time.
  localparam int WR_NS = 15;
  localparam int CK_NS = 15;
  localparam int WR_CYC = (WR_NS + CK_NS - 1) / CK_NS;
  if (WR_CYC * CK_NS < WR_NS)
  begin : g_wr_short
    $error("write recovery count too small");
  end
  // Deselects toggle the address lines so stale values are never seen.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge link_ck);
      cs_b = 1'b1;
      ba = ~ba;
      addr = ~addr;
    end
  endtask : idle
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [15:0] a);
    @(negedge link_ck);
    {cs_b, ras_b, cas_b, we_b} = c;
    ba = b;
    addr = a;
    idle(1);
  endtask : cmd
  task automatic mode(input logic [2:0] b, input logic [15:0] a);
    cmd(ddi_pkg::CMD_MODE_WRITE, b, a);
    idle(GAP);
  endtask : mode
  task automatic mode0(input logic [15:0] a);
    cmd(4'h2, 3'h0, 16'h0400);
    idle(GAP);
    mode(ddi_pkg::SEL_MODE_ZERO, a);
  endtask : mode0
  task automatic term(input logic on);
    @(negedge link_ck);
    termination_ctrl_in = on;
    idle(2);
  endtask : term
  task automatic rst_phase(input int hold);
    @(negedge link_ck);
    cke = 1'b0;
    reset_pin_b = 1'b0;
    repeat (hold) @(negedge link_ck);
    reset_pin_b = 1'b1;
  endtask : rst_phase
  task automatic bring_up(input logic [15:0] mr0);
    idle(WAIT_CYC);
    @(negedge link_ck);
    cke = 1'b1;
    idle(6);
    mode(ddi_pkg::SEL_MODE_TWO, 16'h0);
    mode(ddi_pkg::SEL_MODE_THREE, 16'h0);
    mode(ddi_pkg::SEL_MODE_ONE, 16'h0);
    mode(ddi_pkg::SEL_MODE_ZERO, mr0 | 16'h0100);
    cmd(ddi_pkg::CMD_IMPEDANCE_CAL, 3'h0, 16'h0400);
    idle(4 * GAP);
  endtask : bring_up
endmodule : ddi_ctrl_model

`default_nettype wire

/* ddi_device_tb_top.sv */
// Testbench top for the device command decode and mode setup.
`timescale 1ns/10ps
`default_nettype none

module ddi_device_tb_top;
  logic clock = 1'b0;
  logic link_ck = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] rd_word = 16'h0;
  logic reset_pin_b, cke, cs_b, ras_b, cas_b, we_b, termination_ctrl_in;
  logic dq_oe_b, dqs_out, dqs_oe_b, term_enable, act_strobe, acc_strobe;
  logic acc_write, acc_autopre, acc_chop, mr_strobe, dll_reset, zq_long;
  logic rd_beat_valid, init_ready, cke_seen_sys, cfg_interleave;
  logic [1:0] mr_sel, cfg_burst_mode;
  logic [2:0] ba, act_bank, acc_bank, rd_col;
  logic [9:0] acc_col;
  logic [15:0] addr, dq_out, act_row, mr_data, mode_register_zero;
  int errors = 0;
  int num_checks = 0;

  always #5 clock = ~clock;
  always #7.5 link_ck = ~link_ck;
  always @(negedge link_ck) rd_word <= rd_word + 16'h1;

  ddi_device #(.INIT_CYCLES(20)) i_ddi_device (.*);
  ddi_ctrl_model i_ddi_ctrl_model (.*);

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin : main
    logic [1:0] lo;
    logic [1:0] code;
    logic [15:0] word;
    logic [15:0] ra;
    logic chop;
    logic hi;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      i_ddi_ctrl_model.rst_phase(r == 0 ? 30 : 12);
      chk({init_ready, cke_seen_sys, term_enable}, 20'h0);
      i_ddi_ctrl_model.idle(4);
      i_ddi_ctrl_model.cmd(ddi_pkg::CMD_MODE_WRITE, 3'h0, 16'h000a);
      chk({init_ready, mode_register_zero}, ddi_pkg::MODE_ZERO_RESET);
      i_ddi_ctrl_model.bring_up(16'h0108);
      chk({init_ready, cke_seen_sys, term_enable}, 3'h7);
      chk(mode_register_zero, 16'h0008);
    end
    i_ddi_ctrl_model.term(1'b0);
    chk(term_enable, 1'b0);
    for (int k = 1; k < 4; k++)
    begin
      i_ddi_ctrl_model.mode(k[2:0], 16'h0002);
      chk({mr_sel, mr_data}, {k[1:0], 16'h0002});
    end
    i_ddi_ctrl_model.mode(3'h4, 16'h0003);
    chk({mr_sel, mr_data}, {2'h3, 16'h0002});
    chk(mode_register_zero, 16'h0008);
    i_ddi_ctrl_model.cmd(ddi_pkg::CMD_IMPEDANCE_CAL, 3'h0, 16'h0400);
    chk(zq_long, 1'b1);
    i_ddi_ctrl_model.cmd(ddi_pkg::CMD_IMPEDANCE_CAL, 3'h0, 16'h0000);
    chk(zq_long, 1'b0);
    i_ddi_ctrl_model.cmd(ddi_pkg::CMD_ACTIVE, 3'h6, 16'h7abc);
    chk({act_bank, act_row}, {3'h6, 16'h7abc});
    i_ddi_ctrl_model.cmd(ddi_pkg::CMD_WRITE, 3'h6, 16'h1404);
    chk({acc_chop, acc_write, acc_autopre, acc_col}, {3'h3, 10'h004});
    chk(acc_bank, 3'h6);
    for (int m = 0; m < 4; m++)
      for (int il = 0; il < 2; il++)
      begin
        code = (m == 3) ? ddi_pkg::BURST_ON_THE_FLY : m[1:0];
        chop = (m == 1) || (m == 2);
        word = {12'h0, il[0], 1'b0, code};
        i_ddi_ctrl_model.mode0(word);
        chk(mode_register_zero, word);
        chk({cfg_interleave, cfg_burst_mode}, {il[0], code});
        i_ddi_ctrl_model.cmd(ddi_pkg::CMD_ACTIVE, 3'h1, 16'h0123);
        for (int s = 0; s < 8; s++)
        begin
          ra = {3'h0, m == 3, 9'h0, s[2:0]};
          i_ddi_ctrl_model.cmd(ddi_pkg::CMD_READ, 3'h1, ra);
          chk({acc_chop, acc_col}, {chop, 7'h0, s[2:0]});
          for (int b = 0; b < 8; b++)
          begin
            @(negedge link_ck);
            hi = chop ? s[2] : s[2] ^ b[2];
            lo = il ? s[1:0] ^ b[1:0] : s[1:0] + b[1:0];
            if (chop && b > 3)
              chk({rd_beat_valid, dq_oe_b, dqs_oe_b, dqs_out}, 4'h6);
            else
            begin
              chk({rd_beat_valid, dq_oe_b, rd_col}, {2'h2, hi, lo});
              chk({dqs_out, dq_out}, {!b[0], rd_word});
            end
          end
        end
      end
    close_out();
  end
endmodule : ddi_device_tb_top

bind ddi_device ddi_device_checker i_ddi_device_checker (.*);

`default_nettype wire
